//--- hdl/pwc_pkg.sv
package pwc_pkg;

  localparam int PWC_GENS = 4;
  localparam int PWC_CNT_W = 16;
  localparam int PWC_CH0 = 6;

  // byte offsets and pages of the control registers, index = generator number
  localparam logic [7:0] PWC_GEN0_MASTER_CONTROL_ADDR = 8'hD8;
  localparam logic [7:0] PWC_GEN1_CONTROL_ADDR = 8'hB4;
  localparam logic [7:0] PWC_GEN2_CONTROL_ADDR = 8'hC4;
  localparam logic [7:0] PWC_GEN3_CONTROL_ADDR = 8'hD4;
  localparam logic [1:0] PWC_PAGE0 = 2'h0;
  localparam logic [1:0] PWC_PAGE2 = 2'h2;
  localparam logic [3:0][7:0] PWC_GEN_ADDR = {PWC_GEN3_CONTROL_ADDR, PWC_GEN2_CONTROL_ADDR,
                                              PWC_GEN1_CONTROL_ADDR,
                                              PWC_GEN0_MASTER_CONTROL_ADDR};
  localparam logic [3:0][1:0] PWC_GEN_PAGE = {PWC_PAGE2, PWC_PAGE2, PWC_PAGE2, PWC_PAGE0};
  // bit addresses of the bit-addressable register share its byte offset
  localparam logic [4:0] PWC_BIT_BASE = 5'h1B;

  // field positions
  localparam int PWC_RUN_BIT = 7;
  localparam int PWC_LOAD_BIT = 6;
  localparam int PWC_FLAG_BIT = 5;
  localparam int PWC_CLR_BIT = 4;
  localparam int PWC_RUN3_BIT = 3;
  localparam int PWC_RUN2_BIT = 2;
  localparam int PWC_RUN1_BIT = 1;
  localparam int PWC_BRAKE_EN_BIT = 0;

  localparam logic [7:0] PWC_CTRL_RESET = 8'h00;
  localparam logic [15:0] PWC_CNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    PWC_EVT_PERIOD,
    PWC_EVT_DUTY,
    PWC_EVT_BOTH,
    PWC_EVT_BOTH_ALT
  } pwc_evt_type_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_wr;
    logic [1:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_val;
  } pwc_sfr_req_t;

endpackage

//--- hdl/pwc_gen_unit.sv
`timescale 1ns/100ps
module pwc_gen_unit import pwc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic load_pend,
  input wire logic clr_pend,
  input wire logic [15:0] period_in,
  input wire logic [15:0] duty_in,
  input wire pwc_evt_type_t event_type_select,
  output logic [15:0] counter_reg,
  output logic wave_reg,
  output logic load_done,
  output logic clr_done,
  output logic event_hit
);

  logic [15:0] period_act_reg;
  logic [15:0] duty_act_reg;
  logic period_end;
  logic duty_match;

  assign period_end = run && !clr_pend && (counter_reg == period_act_reg);
  assign duty_match = run && (counter_reg == duty_act_reg);
  assign load_done = period_end && load_pend;
  // the counter is zeroed on the same edge the request drops
  assign clr_done = clr_pend;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      counter_reg <= PWC_CNT_ZERO;
    end else if (clr_pend) begin
      counter_reg <= PWC_CNT_ZERO;
    end else if (run) begin
      if (period_end) begin
        counter_reg <= PWC_CNT_ZERO;
      end else begin
        counter_reg <= counter_reg + 16'h0001;
      end
    end
  end

  // working buffers only change at a period boundary, so a half-written pair never shows
  always_ff @(posedge clk) begin
    if (!rstn) begin
      period_act_reg <= PWC_CNT_ZERO;
      duty_act_reg <= PWC_CNT_ZERO;
    end else if (load_done) begin
      period_act_reg <= period_in;
      duty_act_reg <= duty_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wave_reg <= 1'b0;
    end else begin
      wave_reg <= run && (counter_reg < duty_act_reg);
    end
  end

  always_comb begin
    unique case (event_type_select)
      PWC_EVT_PERIOD: event_hit = period_end;
      PWC_EVT_DUTY: event_hit = duty_match;
      PWC_EVT_BOTH: event_hit = period_end || duty_match;
      PWC_EVT_BOTH_ALT: event_hit = period_end || duty_match;
    endcase
  end

endmodule // pwc_gen_unit

//--- hdl/pwc_run_load_clear_control.sv
`timescale 1ns/100ps
module pwc_run_load_clear_control import pwc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire pwc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata_reg,
  input wire logic [3:0][15:0] period_in,
  input wire logic [3:0][15:0] duty_in,
  input wire pwc_evt_type_t event_type_select,
  input wire logic brake_pin,
  input wire logic brake_edge_select,
  input wire logic [5:0] brake_data,
  output logic [3:0][15:0] gen_counter,
  output logic [3:0] gen_wave,
  output logic [5:0] gen0_out_reg
);

  logic [3:0] run_reg;
  logic [3:0] run_next;
  logic [3:0] load_reg;
  logic [3:0] load_next;
  logic [3:0] flag_reg;
  logic [3:0] flag_next;
  logic [3:0] clr_reg;
  logic [3:0] clr_next;
  logic brake_en_reg;
  logic brake_en_next;
  logic braked_reg;
  logic braked_next;
  logic [3:0][7:0] wr_mask;
  logic [3:0][7:0] wr_val;
  logic [3:0] load_done;
  logic [3:0] clr_done;
  logic [3:0] event_hit;
  logic brake_s1_reg;
  logic brake_s2_reg;
  logic brake_s3_reg;
  logic brake_edge;
  logic brake_event;
  logic bit_hit;
  logic [7:0] rd_val;

  genvar g;
  generate
    for (g = 0; g < PWC_GENS; g++) begin : gen_unit
      pwc_gen_unit u_gen (
        .clk(clk),
        .rstn(rstn),
        .run(run_reg[g]),
        .load_pend(load_reg[g]),
        .clr_pend(clr_reg[g]),
        .period_in(period_in[g]),
        .duty_in(duty_in[g]),
        .event_type_select(event_type_select),
        .counter_reg(gen_counter[g]),
        .wave_reg(gen_wave[g]),
        .load_done(load_done[g]),
        .clr_done(clr_done[g]),
        .event_hit(event_hit[g])
      );
    end
  endgenerate

  // brake pin is asynchronous: two flops, then a third for the edge compare
  always_ff @(posedge clk) begin
    if (!rstn) begin
      brake_s1_reg <= 1'b0;
      brake_s2_reg <= 1'b0;
      brake_s3_reg <= 1'b0;
    end else begin
      brake_s1_reg <= brake_pin;
      brake_s2_reg <= brake_s1_reg;
      brake_s3_reg <= brake_s2_reg;
    end
  end

  assign brake_edge = brake_edge_select ? (brake_s2_reg && !brake_s3_reg)
                                        : (!brake_s2_reg && brake_s3_reg);
  assign brake_event = brake_en_reg && brake_edge;

  assign bit_hit = sfr_req.bit_wr && (sfr_req.page == PWC_GEN_PAGE[0]) &&
                   (sfr_req.addr[7:3] == PWC_BIT_BASE);

  // byte writes and bit operations reduce to one mask and value per register;
  // a byte write wins if both arrive together
  always_comb begin
    for (int i = 0; i < PWC_GENS; i++) begin
      wr_mask[i] = 8'h00;
      wr_val[i] = 8'h00;
      if (sfr_req.wr && sfr_req.page == PWC_GEN_PAGE[i] && sfr_req.addr == PWC_GEN_ADDR[i]) begin
        wr_mask[i] = 8'hFF;
        wr_val[i] = sfr_req.wdata;
      end else if (i == 0 && bit_hit) begin
        wr_mask[i] = 8'h01 << sfr_req.addr[2:0];
        wr_val[i] = {8{sfr_req.bit_val}};
      end
    end
  end

  always_comb begin
    for (int i = 0; i < PWC_GENS; i++) begin
      run_next[i] = run_reg[i];
      if (wr_mask[i][PWC_RUN_BIT]) begin
        run_next[i] = wr_val[i][PWC_RUN_BIT];
      end
      if (i != 0 && wr_mask[0][i]) begin
        run_next[i] = wr_val[0][i];
      end
      // a pending request is only dropped by its own completion
      load_next[i] = (load_reg[i] && !load_done[i]) ||
                     (wr_mask[i][PWC_LOAD_BIT] && wr_val[i][PWC_LOAD_BIT]);
      clr_next[i] = (clr_reg[i] && !clr_done[i]) ||
                    (wr_mask[i][PWC_CLR_BIT] && wr_val[i][PWC_CLR_BIT]);
      // event in the clearing cycle wins so it is not lost
      flag_next[i] = (flag_reg[i] && !(wr_mask[i][PWC_FLAG_BIT] && !wr_val[i][PWC_FLAG_BIT])) ||
                     event_hit[i];
    end
    // software setting run in the same cycle as a brake keeps it running
    if (brake_event && !(wr_mask[0][PWC_RUN_BIT] && wr_val[0][PWC_RUN_BIT])) begin
      run_next[0] = 1'b0;
    end
  end

  always_comb begin
    brake_en_next = brake_en_reg;
    if (wr_mask[0][PWC_BRAKE_EN_BIT]) begin
      brake_en_next = wr_val[0][PWC_BRAKE_EN_BIT];
    end
    braked_next = braked_reg;
    if (wr_mask[0][PWC_RUN_BIT] && wr_val[0][PWC_RUN_BIT]) begin
      braked_next = 1'b0;
    end else if (brake_event) begin
      braked_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_reg <= 4'h0;
      load_reg <= 4'h0;
      flag_reg <= 4'h0;
      clr_reg <= 4'h0;
    end else begin
      run_reg <= run_next;
      load_reg <= load_next;
      flag_reg <= flag_next;
      clr_reg <= clr_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      brake_en_reg <= PWC_CTRL_RESET[PWC_BRAKE_EN_BIT];
      braked_reg <= 1'b0;
    end else begin
      brake_en_reg <= brake_en_next;
      braked_reg <= braked_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gen0_out_reg <= 6'h00;
    end else if (braked_next) begin
      gen0_out_reg <= brake_data;
    end else begin
      gen0_out_reg <= {PWC_CH0{gen_wave[0]}};
    end
  end

  always_comb begin
    rd_val = PWC_CTRL_RESET;
    for (int i = 0; i < PWC_GENS; i++) begin
      if (sfr_req.page == PWC_GEN_PAGE[i] && sfr_req.addr == PWC_GEN_ADDR[i]) begin
        rd_val = {run_reg[i], load_reg[i], flag_reg[i], clr_reg[i], 4'h0};
        if (i == 0) begin
          rd_val[PWC_RUN3_BIT:PWC_BRAKE_EN_BIT] = {run_reg[3:1], brake_en_reg};
        end
      end
    end
  end

  // unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sfr_rdata_reg <= PWC_CTRL_RESET;
    end else if (sfr_req.rd) begin
      sfr_rdata_reg <= rd_val;
    end
  end

endmodule // pwc_run_load_clear_control

//--- sim/pwc_run_load_clear_control_checker.sv
`timescale 1ns/100ps
module pwc_chk import pwc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire pwc_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata_reg,
  input wire logic [5:0] brake_data,
  input wire logic [3:0][15:0] gen_counter,
  input wire logic [5:0] gen0_out_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire g0 = sfr_req.page == 2'h0 && sfr_req.addr == 8'hD8;
  wire w0 = sfr_req.wr && g0;
  wire r0 = sfr_req.rd && g0;
  wire nw = !sfr_req.wr && !sfr_req.bit_wr;
  wire bw = sfr_req.bit_wr && !sfr_req.wr && sfr_req.page == 2'h0 && sfr_req.addr[7:2] == 6'h36;
  sequence s_clr;
    w0 && sfr_req.wdata[4];
  endsequence
  // read-back in a cycle that carries no write, so no later write muddies the bits
  sequence s_rb;
    nw && r0;
  endsequence
  property p_clr;
    s_clr |-> ##2 gen_counter[0] == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("counter not zeroed");
  property p_busy;
    s_clr ##1 r0 |=> sfr_rdata_reg[4];
  endproperty
  a_busy: assert property (p_busy) else $error("clear bit not pending");
  property p_done;
    s_clr ##1 nw ##1 r0 |=> !sfr_rdata_reg[4];
  endproperty
  a_done: assert property (p_done) else $error("clear bit stuck");
  property p_keep;
    s_clr ##1 (w0 && !sfr_req.wdata[4]) |=> gen_counter[0] == 16'h0000;
  endproperty
  a_keep: assert property (p_keep) else $error("clear cancelled");
  property p_idle;
    w0 && !sfr_req.wdata[7] && !sfr_req.wdata[4] ##1 nw |=> $stable(gen_counter[0]);
  endproperty
  a_idle: assert property (p_idle) else $error("idle counter moved");
  property p_runs;
    w0 ##1 s_rb |=> sfr_rdata_reg[3:0] == $past(sfr_req.wdata[3:0], 2);
  endproperty
  a_runs: assert property (p_runs) else $error("low bits lost");
  property p_bit;
    bw ##1 s_rb |=> sfr_rdata_reg[$past(sfr_req.addr[1:0], 2)] == $past(sfr_req.bit_val, 2);
  endproperty
  a_bit: assert property (p_bit) else $error("bit write lost");
  property p_brk;
    gen0_out_reg == 6'h00 || gen0_out_reg == 6'h3F || gen0_out_reg == $past(brake_data);
  endproperty
  a_brk: assert property (p_brk) else $error("bad channel outputs");
endmodule // pwc_chk

bind pwc_run_load_clear_control pwc_chk u_chk (.clk(clk), .rstn(rstn), .sfr_req(sfr_req),
  .sfr_rdata_reg(sfr_rdata_reg), .brake_data(brake_data), .gen_counter(gen_counter),
  .gen0_out_reg(gen0_out_reg));

//--- sim/test_pwc_run_load_clear_control.sv
`timescale 1ns/100ps
module test_pwc_run_load_clear_control import pwc_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic brake_pin = 1'b0;
  logic bsel = 1'b1;
  pwc_evt_type_t et = PWC_EVT_PERIOD;
  logic [3:0][15:0] dty = {4{16'h0002}};
  logic [3:0] wv;
  pwc_sfr_req_t rq = '0;
  logic [3:0][15:0] per = {4{16'h0005}};
  logic [7:0] rdat;
  logic [3:0][15:0] cnt;
  logic [5:0] g0;
  logic [15:0] c;
  int miscompares = 0, tests_run = 0, cyc = 0;
  always #5 clk = ~clk;
  pwc_run_load_clear_control dut (.clk(clk), .rstn(rstn), .sfr_req(rq), .sfr_rdata_reg(rdat),
    .period_in(per), .duty_in(dty), .event_type_select(et),
    .brake_pin(brake_pin), .brake_edge_select(bsel), .brake_data(6'h2A),
    .gen_counter(cnt), .gen_wave(wv), .gen0_out_reg(g0));
  task automatic summarize;
    $display("mismatches %0d checks %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  // k: 4 byte write, 2 read, 1 bit write, 0 idle; one assignment per edge
  task automatic op(input logic [2:0] k, input logic [1:0] p, input logic [7:0] a,
      input logic [7:0] d);
    @(posedge clk);
    rq <= '{wr: k[2], rd: k[1], bit_wr: k[0], page: p, addr: a, wdata: d, bit_val: d[0]};
  endtask
  task automatic rd(input logic [1:0] p, input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
    op(3'h2, p, a, 8'h00);
    op(3'h0, p, a, 8'h00);
    #1 chk(16'(rdat & m), 16'(e));
  endtask
  task automatic wait_load;
    int n;
    n = 0;
    do begin
      op(3'h2, 2'h0, 8'hD8, 8'h00);
      op(3'h0, 2'h0, 8'hD8, 8'h00);
      #1 n++;
    end while (rdat[6] !== 1'b0 && n < 20);
    chk(16'(n < 20), 16'h0001);
  endtask
  task automatic wait_brake;
    int n;
    n = 0;
    while (g0 !== 6'h2A && n < 20) begin
      op(3'h0, 2'h0, 8'h00, 8'h00);
      #1 n++;
    end
  endtask
  // a hang anywhere ends here rather than running on forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    logic [15:0] mx;
    logic [15:0] hi;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(PWC_GEN_PAGE[i], PWC_GEN_ADDR[i], 8'hFF, 8'h00);
    op(3'h4, 2'h0, 8'hD8, 8'h0E);
    rd(2'h0, 8'hD8, 8'hFF, 8'h0E);
    rd(2'h2, 8'hB4, 8'h80, 8'h80);
    rd(2'h2, 8'hD4, 8'h80, 8'h80);
    op(3'h4, 2'h2, 8'hC4, 8'h00);
    rd(2'h0, 8'hD8, 8'h0F, 8'h0A);
    op(3'h4, 2'h0, 8'hD8, 8'hC0);
    wait_load();
    c = cnt[0];
    op(3'h0, 2'h0, 8'h00, 8'h00);
    per[0] <= 16'h0003;
    #1 chk(16'(cnt[0] !== c), 16'h0001);
    op(3'h4, 2'h0, 8'hD8, 8'hD0);
    op(3'h4, 2'h0, 8'hD8, 8'h80);
    rd(2'h0, 8'hD8, 8'h50, 8'h40);
    wait_load();
    mx = 16'h0000;
    hi = 16'h0000;
    repeat (8) begin
      op(3'h0, 2'h0, 8'h00, 8'h00);
      #1 if (cnt[0] > mx) mx = cnt[0];
      hi = hi + 16'(wv[0]);
    end
    chk(mx, 16'h0003);
    // duty 2 in a period of 3 gives two high cycles in every four
    chk(hi, 16'h0004);
    rd(2'h0, 8'hD8, 8'h20, 8'h20);
    op(3'h4, 2'h0, 8'hD8, 8'h20);
    rd(2'h0, 8'hD8, 8'hFF, 8'h20);
    c = cnt[0];
    op(3'h0, 2'h0, 8'h00, 8'h00);
    #1 chk(cnt[0], c);
    op(3'h4, 2'h0, 8'hD8, 8'h00);
    rd(2'h0, 8'hD8, 8'hFF, 8'h00);
    op(3'h4, 2'h0, 8'hD8, 8'h10);
    rd(2'h0, 8'hD8, 8'h10, 8'h10);
    op(3'h4, 2'h0, 8'hD8, 8'h10);
    op(3'h0, 2'h0, 8'h00, 8'h00);
    rd(2'h0, 8'hD8, 8'h10, 8'h00);
    chk(cnt[0], 16'h0000);
    op(3'h1, 2'h0, 8'hDB, 8'h01);
    op(3'h1, 2'h0, 8'hD8, 8'h01);
    rd(2'h0, 8'hD8, 8'hFF, 8'h09);
    op(3'h1, 2'h0, 8'hDB, 8'h00);
    rd(2'h0, 8'hD8, 8'hFF, 8'h01);
    op(3'h1, 2'h0, 8'hDF, 8'h01);
    brake_pin <= 1'b1;
    wait_brake();
    chk(16'(g0), 16'h002A);
    rd(2'h0, 8'hD8, 8'h80, 8'h00);
    op(3'h1, 2'h0, 8'hDF, 8'h01);
    repeat (3) op(3'h0, 2'h0, 8'h00, 8'h00);
    #1 chk(16'(g0 == 6'h00 || g0 == 6'h3F), 16'h0001);
    rd(2'h0, 8'hD8, 8'h80, 8'h80);
    // a duty above the period never matches, so in duty mode nothing can raise the flag
    op(3'h4, 2'h0, 8'hD8, 8'hC1);
    et <= PWC_EVT_DUTY;
    dty[0] <= 16'h0009;
    wait_load();
    op(3'h4, 2'h0, 8'hD8, 8'h81);
    repeat (6) op(3'h0, 2'h0, 8'h00, 8'h00);
    rd(2'h0, 8'hD8, 8'h20, 8'h00);
    op(3'h0, 2'h0, 8'h00, 8'h00);
    et <= PWC_EVT_BOTH;
    repeat (5) op(3'h0, 2'h0, 8'h00, 8'h00);
    rd(2'h0, 8'hD8, 8'h20, 8'h20);
    op(3'h4, 2'h2, 8'hB4, 8'hC0);
    repeat (2) op(3'h0, 2'h0, 8'h00, 8'h00);
    #1 c = cnt[1];
    op(3'h0, 2'h0, 8'h00, 8'h00);
    #1 chk(16'(cnt[1] !== c), 16'h0001);
    rd(2'h2, 8'hB4, 8'h40, 8'h00);
    // falling-edge brake: pin is high here, so the select change alone makes no edge
    op(3'h0, 2'h0, 8'h00, 8'h00);
    bsel <= 1'b0;
    brake_pin <= 1'b0;
    wait_brake();
    chk(16'(g0), 16'h002A);
    rd(2'h0, 8'hD8, 8'h80, 8'h00);
    op(3'h0, 2'h0, 8'h00, 8'h00);
    rstn <= 1'b0;
    repeat (4) op(3'h0, 2'h0, 8'h00, 8'h00);
    rstn <= 1'b1;
    rd(2'h0, 8'hD8, 8'hFF, 8'h00);
    chk(cnt[1], 16'h0000);
    rd(2'h2, 8'hD8, 8'hFF, 8'h00);
    rd(2'h1, 8'hB4, 8'hFF, 8'h00);
    summarize();
  end
endmodule // test_pwc_run_load_clear_control
